// *** design/hmd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none

module hmd_decoder
   import hmd_pkg::*;
#(
   parameter int unsigned BUF_WORDS = HMD_BUF_WORDS,
   parameter int unsigned PHY_WORDS = HMD_PHY_WORDS
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        mode_sel_i,
   input  wire logic        wide_i,
   input  wire logic        latch_i,
   input  wire hmd_req_t    req_i,
   input  wire logic        ptr_valid_i,
   input  wire logic        ptr_write_i,
   input  wire logic [14:0] ptr_addr_i,
   input  wire logic [7:0]  ptr_wdata_i,
   input  wire hmd_dma_t    dma_i,
   input  wire logic        mii_valid_i,
   input  wire logic        mii_write_i,
   input  wire logic [4:0]  mii_addr_i,
   input  wire logic [15:0] mii_wdata_i,
   output hmd_rsp_t         rsp_o,
   output logic             ptr_rvalid_o,
   output logic [7:0]       ptr_rdata_o,
   output logic             dma_rvalid_o,
   output logic [7:0]       dma_rdata_o,
   output logic             mii_rvalid_o,
   output logic [15:0]      mii_rdata_o,
   output logic             serial_mode_o,
   output logic             cs_pullup_en_o,
   output logic             cs_pulldown_en_o
);

   // =====================================================================
   // Interface mode capture
   // =====================================================================
   logic serial_mode;
   logic wide_mode;
   logic mode_taken;

   // The strap is caught by a clocked process after reset, never by reset.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_mode <= 1'b1;
         wide_mode   <= 1'b0;
         mode_taken  <= 1'b0;
      end else if (latch_i && !mode_taken) begin
         serial_mode <= mode_sel_i;
         wide_mode   <= wide_i;
         mode_taken  <= 1'b1;
      end
   end

   // Pull selection follows the latched mode so an idle pin reads deselected.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_mode_o    <= 1'b1;
         cs_pullup_en_o   <= 1'b1;
         cs_pulldown_en_o <= 1'b0;
      end else begin
         serial_mode_o    <= serial_mode;
         cs_pullup_en_o   <= serial_mode;
         cs_pulldown_en_o <= !serial_mode;
      end
   end

   // =====================================================================
   // Host address decode
   // =====================================================================
   logic [14:0] byte_addr;
   logic        hit_buf;
   logic        hit_crypt;
   logic        hit_sreg;
   logic        hit_set;
   logic        hit_clr;
   logic [7:0]  sreg_lin;
   logic [14:0] par_off;
   logic        sreg_impl;
   logic        host_sreg;
   logic        host_buf;
   hmd_kind_t   host_kind;

   // Wide modes carry a word address; it becomes a byte address here.
   assign byte_addr = wide_mode ? {req_i.addr[13:0], 1'b0}
                                : req_i.addr;

   function automatic logic in_range(input logic [14:0] a,
                                     input logic [14:0] lo,
                                     input logic [14:0] span);
      in_range = ({1'b0, a} >= {1'b0, lo})
              && ({1'b0, a} < {1'b0, lo} + {1'b0, span});
   endfunction

   assign hit_buf   = byte_addr <= HMD_BUF_LAST;
   assign hit_crypt = (byte_addr >= HMD_CRYPT_FIRST)
                   && (byte_addr <= HMD_CRYPT_LAST);
   // Aliases sit above the register block; AD14..9 high still lands here.
   assign hit_sreg  = in_range(byte_addr, HMD_SREG_BASE,
                               HMD_ALIAS_SPAN);
   assign hit_set   = in_range(byte_addr, HMD_SET_BASE, HMD_ALIAS_SPAN)
                   && !hit_clr;
   assign hit_clr   = in_range(byte_addr, HMD_CLR_BASE, HMD_ALIAS_SPAN);

   assign par_off = hit_set ? (byte_addr - HMD_SET_BASE) :
                    hit_clr ? (byte_addr - HMD_CLR_BASE) :
                              (byte_addr - HMD_SREG_BASE);

   // Serial: banked addresses prefix the bank, unbanked use 8-bit linear.
   assign sreg_lin = req_i.banked
                   ? {1'b0, req_i.bank, req_i.addr[4:0]}
                   : req_i.addr[7:0];

   // Serial mode offers no direct buffer route at all.
   assign host_sreg = req_i.valid
                   && (serial_mode || hit_sreg || hit_set || hit_clr);
   assign host_buf  = req_i.valid && !serial_mode && hit_buf;
   assign sreg_impl = serial_mode ? (sreg_lin < 8'(HMD_SREG_BYTES))
                                  : 1'b1;

   assign host_kind =
      !req_i.write || !sreg_impl ? HMD_AK_NONE :
      req_i.bit_set || (!serial_mode && hit_set) ? HMD_AK_SET :
      req_i.bit_clr || (!serial_mode && hit_clr) ? HMD_AK_CLR :
                                                   HMD_AK_WRITE;

   // Byte address picks the register; its low bit picks the lane, save in 16-bit parallel mode where be does.
   logic [7:0]  reg_byte;
   logic [1:0]  reg_be;
   logic [15:0] reg_wdata;
   assign reg_byte  = serial_mode ? sreg_lin : par_off[7:0];
   assign reg_be    = (wide_mode && !serial_mode) ? req_i.be
                    : (reg_byte[0] ? 2'b10 : 2'b01);
   assign reg_wdata = (wide_mode && !serial_mode) ? req_i.wdata
                    : {req_i.wdata[7:0], req_i.wdata[7:0]};

   logic [15:0] sreg_rdata;
   hmd_sreg_file #(
      .WORDS (HMD_SREG_WORDS),
      .AW    (HMD_SREG_AW)
   ) u_sreg (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .en_i      (host_sreg && sreg_impl),
      .kind_i    (host_kind),
      .be_i      (reg_be),
      .idx_i     (reg_byte[7:1]),
      .wdata_i   (reg_wdata),
      .rdata_o   (sreg_rdata)
   );

   // =====================================================================
   // Packet buffer arbitration
   // =====================================================================
   // Pointer traffic wins over direct host traffic; the host is parallel
   // only and the pointer engine is sparse, so no starvation arises.
   logic        ptr_go;
   logic        buf_en;
   logic [1:0]  buf_we;
   logic [13:0] buf_waddr;
   logic [15:0] buf_wdata;
   logic [15:0] buf_rdata;
   logic        ptr_hit;

   assign ptr_hit   = ptr_addr_i <= HMD_BUF_LAST;
   assign ptr_go    = ptr_valid_i && ptr_hit;
   assign buf_en    = ptr_go || host_buf;
   assign buf_waddr = ptr_go ? ptr_addr_i[14:1] : byte_addr[14:1];
   assign buf_we    = !buf_en ? 2'b00 :
                      ptr_go ? (ptr_write_i ? (ptr_addr_i[0] ? 2'b10
                                                             : 2'b01)
                                            : 2'b00) :
                      !req_i.write ? 2'b00 :
                      wide_mode ? req_i.be :
                      (byte_addr[0] ? 2'b10 : 2'b01);
   assign buf_wdata = ptr_go ? {ptr_wdata_i, ptr_wdata_i}
                    : (wide_mode ? req_i.wdata
                                 : {req_i.wdata[7:0], req_i.wdata[7:0]});

   hmd_ram #(
      .WORDS (BUF_WORDS),
      .AW    (HMD_BUF_AW)
   ) u_buf (
      .sys_clk_i (sys_clk_i),
      .en_i      (buf_en),
      .we_i      (buf_we),
      .addr_i    (buf_waddr),
      .wdata_i   (buf_wdata),
      .rdata_o   (buf_rdata)
   );

   // =====================================================================
   // Cryptographic store and PHY space
   // =====================================================================
   logic [7:0] crypt [1104];
   logic       dma_hit;
   logic [10:0] crypt_idx;
   logic [14:0] crypt_off;
   logic [15:0] phy [PHY_WORDS];

   assign dma_hit   = dma_i.valid && (dma_i.addr >= HMD_CRYPT_FIRST)
                   && (dma_i.addr <= HMD_CRYPT_LAST);
   assign crypt_off = dma_i.addr - HMD_CRYPT_FIRST;
   assign crypt_idx = crypt_off[10:0];

   // Only the DMA port has wires into this store; the host has none.
   always_ff @(posedge sys_clk_i) begin
      if (dma_hit && dma_i.write) begin
         crypt[crypt_idx] <= dma_i.wdata;
      end
      if (dma_hit) begin
         dma_rdata_o <= crypt[crypt_idx];
      end
      if (mii_valid_i && mii_write_i) begin
         phy[mii_addr_i] <= mii_wdata_i;
      end
      if (mii_valid_i) begin
         mii_rdata_o <= phy[mii_addr_i];
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dma_rvalid_o <= 1'b0;
         mii_rvalid_o <= 1'b0;
      end else begin
         dma_rvalid_o <= dma_hit && !dma_i.write;
         mii_rvalid_o <= mii_valid_i && !mii_write_i;
      end
   end

   // =====================================================================
   // Read return
   // =====================================================================
   typedef enum logic [1:0] {
      SRC_ZERO = 2'h0,
      SRC_SREG = 2'h1,
      SRC_BUF  = 2'h2
   } hmd_src_t;

   hmd_src_t   src, next_src;
   logic       rd_pend, ptr_pend, lane_hi, ptr_lane;
   logic [15:0] next_rdata;
   logic [15:0] pick;

   // Crypto, gap and unimplemented reads all select the zero source.
   assign next_src = host_buf ? SRC_BUF :
                     (host_sreg && sreg_impl) ? SRC_SREG :
                     SRC_ZERO;
   assign pick = (src == SRC_BUF)  ? buf_rdata :
                 (src == SRC_SREG) ? sreg_rdata : HMD_READ_ZERO;
   assign next_rdata = (wide_mode && !serial_mode) ? pick
                     : {8'h00, lane_hi ? pick[15:8] : pick[7:0]};

   // Data arrives one cycle after the request; answer is registered then.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         src          <= SRC_ZERO;
         rd_pend      <= 1'b0;
         lane_hi      <= 1'b0;
         ptr_pend     <= 1'b0;
         ptr_lane     <= 1'b0;
         rsp_o        <= '0;
         ptr_rvalid_o <= 1'b0;
         ptr_rdata_o  <= 8'h00;
      end else begin
         src          <= next_src;
         rd_pend      <= req_i.valid && !req_i.write;
         lane_hi      <= serial_mode ? sreg_lin[0] : byte_addr[0];
         ptr_pend     <= ptr_go && !ptr_write_i;
         ptr_lane     <= ptr_addr_i[0];
         rsp_o.valid  <= rd_pend;
         rsp_o.rdata  <= next_rdata;
         ptr_rvalid_o <= ptr_pend;
         ptr_rdata_o  <= ptr_lane ? buf_rdata[15:8] : buf_rdata[7:0];
      end
   end

endmodule // hmd_decoder

`default_nettype wire

// *** design/hmd_pkg.sv ***
package hmd_pkg;

   // =====================================================================
   // Address space sizes and region bounds
   // =====================================================================
   localparam int unsigned HMD_ADDR_W        = 15;
   localparam int unsigned HMD_BUF_WORDS     = 12288;
   localparam int unsigned HMD_BUF_AW        = 14;
   localparam int unsigned HMD_PHY_WORDS     = 32;
   localparam int unsigned HMD_PHY_AW        = 5;
   localparam int unsigned HMD_SREG_BYTES    = 160;
   localparam int unsigned HMD_SREG_WORDS    = 80;
   localparam int unsigned HMD_SREG_AW       = 7;
   localparam int unsigned HMD_BANK_BYTES    = 32;

   localparam logic [14:0] HMD_BUF_LAST      = 15'h5fff;
   localparam logic [14:0] HMD_CRYPT_FIRST   = 15'h7800;
   localparam logic [14:0] HMD_CRYPT_LAST    = 15'h7c4f;
   localparam logic [14:0] HMD_SREG_BASE     = 15'h7e00;
   localparam logic [14:0] HMD_SET_BASE      = 15'h7f00;
   localparam logic [14:0] HMD_CLR_BASE      = 15'h7f80;
   localparam logic [14:0] HMD_ALIAS_SPAN    = 15'h00a0;
   localparam logic [7:0]  HMD_UNBANKED_BASE = 8'h80;
   localparam logic [15:0] HMD_SREG_RESET    = 16'h0000;
   localparam logic [15:0] HMD_READ_ZERO     = 16'h0000;

   // =====================================================================
   // Access kinds, access states and port structures
   // =====================================================================
   typedef enum logic [3:0] {
      HMD_AK_NONE  = 4'h1,
      HMD_AK_WRITE = 4'h2,
      HMD_AK_SET   = 4'h4,
      HMD_AK_CLR   = 4'h8
   } hmd_kind_t;

   typedef enum logic [2:0] {
      HMD_ST_IDLE = 3'h1,
      HMD_ST_READ = 3'h2,
      HMD_ST_DONE = 3'h4
   } hmd_state_t;

   // Host access request. Serial mode uses addr as a register
   // address; parallel modes use it as the external bus address.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        bit_set;
      logic        bit_clr;
      logic        banked;
      logic [1:0]  bank;
      logic [14:0] addr;
      logic [1:0]  be;
      logic [15:0] wdata;
   } hmd_req_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] rdata;
   } hmd_rsp_t;

   // Internal DMA port into the cryptographic store, byte addressed.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [14:0] addr;
      logic [7:0]  wdata;
   } hmd_dma_t;

endpackage : hmd_pkg

// *** design/hmd_ram.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Word memory with per-byte write enables and a registered read port
// =====================================================================
module hmd_ram #(
   parameter int unsigned WORDS = 12288,
   parameter int unsigned AW    = 14
) (
   input  wire logic          sys_clk_i,
   input  wire logic          en_i,
   input  wire logic [1:0]    we_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [15:0]   wdata_i,
   output logic      [15:0]   rdata_o
);

   logic [15:0] mem [WORDS];

   // Each byte lane writes alone so the other byte of the word survives.
   always_ff @(posedge sys_clk_i) begin
      if (en_i && we_i[0]) begin
         mem[addr_i][7:0] <= wdata_i[7:0];
      end
      if (en_i && we_i[1]) begin
         mem[addr_i][15:8] <= wdata_i[15:8];
      end
      if (en_i) begin
         rdata_o <= mem[addr_i];
      end
   end

endmodule // hmd_ram

`default_nettype wire

// *** design/hmd_sreg_file.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Special register storage: 16-bit words with write, set and clear
// =====================================================================
module hmd_sreg_file
   import hmd_pkg::*;
#(
   parameter int unsigned WORDS = 80,
   parameter int unsigned AW    = 7
) (
   input  wire logic          sys_clk_i,
   input  wire logic          rst_i,
   input  wire logic          en_i,
   input  wire hmd_kind_t     kind_i,
   input  wire logic [1:0]    be_i,
   input  wire logic [AW-1:0] idx_i,
   input  wire logic [15:0]   wdata_i,
   output logic      [15:0]   rdata_o
);

   logic [15:0] regs [WORDS];
   logic [15:0] mask;
   logic [15:0] cur;
   logic [15:0] next_word;

   // Byte enables widen to a bit mask shared by all three write kinds.
   assign mask = {{8{be_i[1]}}, {8{be_i[0]}}};
   assign cur  = regs[idx_i];
   assign next_word =
      (kind_i == HMD_AK_SET) ? (cur | (wdata_i & mask)) :
      (kind_i == HMD_AK_CLR) ? (cur & ~(wdata_i & mask)) :
                               ((cur & ~mask) | (wdata_i & mask));

   // Registers clear at reset so unwritten locations read zero.
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < WORDS; i++) begin
            regs[i] <= HMD_SREG_RESET;
         end
         rdata_o <= HMD_SREG_RESET;
      end else begin
         if (en_i && kind_i != HMD_AK_NONE) begin
            regs[idx_i] <= next_word;
         end
         if (en_i) begin
            rdata_o <= cur;
         end
      end
   end

endmodule // hmd_sreg_file

`default_nettype wire

// *** dv/hmd_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Port checker for the host memory map decoder
// =====================================================================
module hmd_monitor
   import hmd_pkg::*;
#(
   parameter int unsigned BUF_WORDS = HMD_BUF_WORDS,
   parameter int unsigned PHY_WORDS = HMD_PHY_WORDS
) (
   input wire logic        sys_clk_i,
   input wire logic        rst_i,
   input wire logic        wide_i,
   input wire hmd_req_t    req_i,
   input wire logic        ptr_valid_i,
   input wire logic        ptr_write_i,
   input wire logic [14:0] ptr_addr_i,
   input wire hmd_dma_t    dma_i,
   input wire logic        mii_valid_i,
   input wire logic        mii_write_i,
   input wire hmd_rsp_t    rsp_o,
   input wire logic        ptr_rvalid_o,
   input wire logic        dma_rvalid_o,
   input wire logic        mii_rvalid_o,
   input wire logic        serial_mode_o,
   input wire logic        cs_pullup_en_o,
   input wire logic        cs_pulldown_en_o
);
   // Plain host reads, the 8-bit parallel ones, and pointer reads.
   wire logic rd = req_i.valid & ~req_i.write & ~req_i.bit_set
                   & ~req_i.bit_clr;
   wire logic pb = rd & ~serial_mode_o & ~wide_i;
   wire logic pr = ptr_valid_i & ~ptr_write_i;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   // The pulls change on the same edge as the mode; the check still waits for a settled mode.
   pull_serial_a:
   assert property (serial_mode_o && $past(serial_mode_o, 2)
                    |-> cs_pullup_en_o && !cs_pulldown_en_o)
      else $error("serial mode without lone pull-up");
   pull_par_a:
   assert property (!serial_mode_o && !$past(serial_mode_o, 2)
                    |-> cs_pulldown_en_o && !cs_pullup_en_o)
      else $error("parallel mode without lone pull-down");
   phy_answer_a:
   assert property (mii_valid_i && !mii_write_i |=> mii_rvalid_o)
      else $error("phy read not answered next cycle");
   host_answer_a:
   assert property (rd |-> ##2 rsp_o.valid)
      else $error("host read not answered after two cycles");
   write_quiet_a:
   assert property (req_i.valid && req_i.write |-> ##2 !rsp_o.valid)
      else $error("host write produced a read answer");
   crypt_dark_a:
   assert property (pb && req_i.addr inside {[15'h7800:15'h7c4f]}
                    |-> ##2 rsp_o.rdata[7:0] == 8'h00)
      else $error("host read reached the crypto store");
   dma_answer_a:
   assert property (dma_i.valid && !dma_i.write
                    && dma_i.addr inside {[15'h7800:15'h7c4f]}
                    |=> dma_rvalid_o)
      else $error("dma read not answered next cycle");
   gap_dark_a:
   assert property (pb && req_i.addr inside {[15'h6000:15'h77ff]}
                    |-> ##2 rsp_o.rdata[7:0] == 8'h00)
      else $error("gap read returned nonzero data");
   ptr_answer_a:
   assert property (pr && ptr_addr_i <= 15'h5fff |-> ##2 ptr_rvalid_o)
      else $error("pointer read not answered after two cycles");
   ptr_bound_a:
   assert property (pr && ptr_addr_i > 15'h5fff |-> ##2 !ptr_rvalid_o)
      else $error("pointer read beyond buffer answered");
   unimpl_zero_a:
   assert property (rd && serial_mode_o && !req_i.banked
                    && req_i.addr inside {[15'h00a0:15'h00ff]}
                    |-> ##2 rsp_o.rdata[7:0] == 8'h00)
      else $error("unimplemented register read nonzero");

endmodule // hmd_monitor
`default_nettype wire

// *** dv/hmd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Host model issuing one request at a time
// =====================================================================
module hmd_host_model
   import hmd_pkg::*;
(
   input  wire logic     sys_clk_i,
   input  wire hmd_rsp_t rsp_i,
   output var hmd_req_t  req_o
);
   initial begin
      req_o = '0;
   end

   // op is {write, bit_set, bit_clr, banked}. The request holds until the
   // edge that takes it; a released bus shows inverted address and data so
   // a stale value is never mistaken for a live one. The bench hands it no
   // reserved register to write and it returns the data read back in q.
   task automatic access(
      input  logic [3:0]  op,
      input  logic [1:0]  bk,
      input  logic [14:0] a,
      input  logic [1:0]  be,
      input  logic [15:0] d,
      output logic [15:0] q,
      output logic        ok
   );
      int n;
      q = 16'hxxxx;
      ok = op[3:1] != 3'h0;
      @(posedge sys_clk_i);
      req_o <= '{1'b1, op[3], op[2], op[1], op[0], bk, a, be, d};
      @(posedge sys_clk_i);
      req_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, bk, ~a, be, ~d};
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge sys_clk_i);
         #1;
         if (rsp_i.valid === 1'b1) begin
            q = rsp_i.rdata;
            ok = 1'b1;
         end
      end
   endtask

endmodule // hmd_host_model
`default_nettype wire

// *** dv/test_hmd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Self-checking bench for the host memory map decoder
// =====================================================================
module test_hmd_decoder;
   import hmd_pkg::*;

   localparam int unsigned BUF_WORDS = HMD_BUF_WORDS;
   localparam int unsigned PHY_WORDS = HMD_PHY_WORDS;

   typedef struct packed {
      logic [14:0] wa;
      logic [7:0]  wd;
      logic [14:0] ra;
      logic [7:0]  ex;
   } hmd_row_t;

   logic        clk, rst, mode_sel, wide, latch;
   hmd_req_t    req;
   hmd_dma_t    dma;
   hmd_rsp_t    rsp;
   logic        ptr_v, ptr_w, mii_v, mii_w;
   logic [14:0] ptr_a;
   logic [7:0]  ptr_d, ptr_q, dma_q;
   logic [4:0]  mii_a;
   logic [15:0] mii_d, mii_q, q;
   logic        ptr_rv, dma_rv, mii_rv, ser, pu, pd, ok;
   int          err_count;
   int          comparisons;

   // 8-bit parallel rows: write one place, read one, expected byte.
   hmd_row_t rows [10] = '{
      '{15'h0000, 8'ha5, 15'h0000, 8'ha5},
      '{15'h5fff, 8'h3c, 15'h5fff, 8'h3c},
      '{15'h6000, 8'h77, 15'h6000, 8'h00},
      '{15'h77ff, 8'h78, 15'h77ff, 8'h00},
      '{15'h7800, 8'h11, 15'h7800, 8'h00},
      '{15'h7c4f, 8'h22, 15'h7c4f, 8'h00},
      '{15'h7e00, 8'h5a, 15'h7e00, 8'h5a},
      '{15'h7e01, 8'hc3, 15'h7e01, 8'hc3},
      '{15'h7f00, 8'h0f, 15'h7e00, 8'h5f},
      '{15'h7f80, 8'h50, 15'h7e00, 8'h0f}
   };

   hmd_decoder #(.BUF_WORDS(BUF_WORDS), .PHY_WORDS(PHY_WORDS)) u_hmd_decoder (
      .sys_clk_i(clk), .rst_i(rst), .mode_sel_i(mode_sel), .wide_i(wide),
      .latch_i(latch), .req_i(req), .ptr_valid_i(ptr_v),
      .ptr_write_i(ptr_w), .ptr_addr_i(ptr_a), .ptr_wdata_i(ptr_d),
      .dma_i(dma), .mii_valid_i(mii_v), .mii_write_i(mii_w),
      .mii_addr_i(mii_a), .mii_wdata_i(mii_d), .rsp_o(rsp),
      .ptr_rvalid_o(ptr_rv), .ptr_rdata_o(ptr_q), .dma_rvalid_o(dma_rv),
      .dma_rdata_o(dma_q), .mii_rvalid_o(mii_rv), .mii_rdata_o(mii_q),
      .serial_mode_o(ser), .cs_pullup_en_o(pu), .cs_pulldown_en_o(pd)
   );

   hmd_host_model u_hmd_host_model (
      .sys_clk_i(clk),
      .rsp_i(rsp),
      .req_o(req)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string n, input logic [15:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // A host request that never answers ends the run at once.
   task automatic host(input logic [3:0] op, input logic [1:0] bk,
                       input logic [14:0] a, input logic [1:0] be,
                       input logic [15:0] d);
      u_hmd_host_model.access(op, bk, a, be, d, q, ok);
      if (!ok) begin
         err_count++;
         stop_test();
      end
   endtask

   // Internal access: 0 pointer, 1 DMA, 2 PHY path; nv means no answer due.
   task automatic side(input int k, input logic w, input logic nv,
                       input logic [14:0] a, input logic [15:0] d);
      int n;
      @(posedge clk);
      ptr_v <= (k == 0);
      dma.valid <= (k == 1);
      mii_v <= (k == 2);
      ptr_w <= w;
      dma.write <= w;
      mii_w <= w;
      ptr_a <= a;
      dma.addr <= a;
      mii_a <= a[4:0];
      ptr_d <= d[7:0];
      dma.wdata <= d[7:0];
      mii_d <= d;
      @(posedge clk);
      ptr_v <= 1'b0;
      dma.valid <= 1'b0;
      mii_v <= 1'b0;
      ok = w;
      for (n = 0; n < 4 && !ok; n++) begin
         #1;
         ok = (k == 0) ? ptr_rv === 1'b1 : (k == 1) ? dma_rv === 1'b1
            : mii_rv === 1'b1;
         q = (k == 0) ? {8'h00, ptr_q} : (k == 1) ? {8'h00, dma_q} : mii_q;
         if (!ok) @(posedge clk);
      end
      if (!ok && !nv) begin
         err_count++;
         stop_test();
      end
   endtask

   // Resets for four cycles, then latches the straps once.
   task automatic start(input logic s, input logic w);
      @(posedge clk);
      rst <= 1'b1;
      mode_sel <= s;
      wide <= w;
      repeat (3) @(posedge clk);
      #1;
      chk("rst_pulls", {13'h0, ser, pu, pd}, 16'h0006);
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      latch <= 1'b1;
      @(posedge clk);
      latch <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("pulls", {13'h0, ser, pu, pd}, s ? 16'h0006 : 16'h0001);
   endtask

   initial begin
      rst = 1'b1;
      mode_sel = 1'b1;
      wide = 1'b0;
      latch = 1'b0;
      ptr_v = 1'b0;
      ptr_w = 1'b0;
      ptr_a = 15'h0000;
      ptr_d = 8'h00;
      dma = '0;
      mii_v = 1'b0;
      mii_w = 1'b0;
      mii_a = 5'h00;
      mii_d = 16'h0000;
      err_count = 0;
      comparisons = 0;
      start(1'b0, 1'b0);
      foreach (rows[i]) begin
         host(4'h8, 2'h0, rows[i].wa, 2'h1, 16'(rows[i].wd));
         host(4'h0, 2'h0, rows[i].ra, 2'h1, 16'h0000);
         chk("row", 16'(q[7:0]), 16'(rows[i].ex));
      end
      // Host writes into the crypto store must leave DMA data intact.
      side(1, 1'b1, 1'b0, 15'h7800, 16'h0066);
      host(4'h8, 2'h0, 15'h7800, 2'h1, 16'h0011);
      side(1, 1'b0, 1'b0, 15'h7800, 16'h0000);
      chk("dma", q, 16'h0066);
      host(4'h8, 2'h0, 15'h0010, 2'h1, 16'h0099);
      side(0, 1'b0, 1'b0, 15'h0010, 16'h0000);
      chk("ptr_rd", q, 16'h0099);
      side(0, 1'b1, 1'b0, 15'h0011, 16'h0044);
      host(4'h0, 2'h0, 15'h0011, 2'h1, 16'h0000);
      chk("host_rd", 16'(q[7:0]), 16'h0044);
      side(0, 1'b0, 1'b1, 15'h6000, 16'h0000);
      chk("ptr_off", {15'h0000, ok}, 16'h0000);
      // Serial mode: banks, linear addresses and the PHY path.
      start(1'b1, 1'b0);
      side(2, 1'b1, 1'b0, 15'h001f, 16'h1234);
      side(2, 1'b0, 1'b0, 15'h001f, 16'h0000);
      chk("phy", q, 16'h1234);
      host(4'h9, 2'h1, 15'h0000, 2'h1, 16'h0021);
      host(4'h0, 2'h0, 15'h0020, 2'h1, 16'h0000);
      chk("bank1", 16'(q[7:0]), 16'h0021);
      host(4'h9, 2'h3, 15'h0005, 2'h1, 16'h00ab);
      host(4'h0, 2'h0, 15'h0065, 2'h1, 16'h0000);
      chk("bank3", 16'(q[7:0]), 16'h00ab);
      host(4'h8, 2'h0, 15'h0041, 2'h1, 16'h0099);
      host(4'h1, 2'h2, 15'h0001, 2'h1, 16'h0000);
      chk("linear", 16'(q[7:0]), 16'h0099);
      host(4'h8, 2'h0, 15'h0085, 2'h1, 16'h005a);
      host(4'h0, 2'h0, 15'h0085, 2'h1, 16'h0000);
      chk("unbanked", 16'(q[7:0]), 16'h005a);
      side(0, 1'b1, 1'b0, 15'h0003, 16'h007e);
      host(4'h0, 2'h0, 15'h0003, 2'h1, 16'h0000);
      chk("no_buf", 16'(q[7:0]), 16'h0000);
      host(4'h0, 2'h0, 15'h00a0, 2'h1, 16'h0000);
      chk("unimpl", 16'(q[7:0]), 16'h0000);
      // 16-bit parallel mode: lanes, word addressing, byte order.
      start(1'b0, 1'b1);
      host(4'h8, 2'h0, 15'h0008, 2'h3, 16'hbeef);
      host(4'h8, 2'h0, 15'h0008, 2'h1, 16'h0012);
      host(4'h0, 2'h0, 15'h0008, 2'h3, 16'h0000);
      chk("bytewr", q, 16'hbe12);
      side(0, 1'b0, 1'b0, 15'h0011, 16'h0000);
      chk("ptr_hi", q, 16'h00be);
      host(4'h8, 2'h0, 15'h2fff, 2'h3, 16'h5aa5);
      side(0, 1'b0, 1'b0, 15'h5ffe, 16'h0000);
      chk("last_lo", q, 16'h00a5);
      host(4'h8, 2'h0, 15'h3f00, 2'h3, 16'h1234);
      host(4'h0, 2'h0, 15'h3f00, 2'h3, 16'h0000);
      chk("reg16", q, 16'h1234);
      stop_test();
   end

endmodule // test_hmd_decoder

bind hmd_decoder hmd_monitor #(
   .BUF_WORDS(BUF_WORDS),
   .PHY_WORDS(PHY_WORDS)
) u_hmd_monitor (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wide_i(wide_i), .req_i(req_i),
   .ptr_valid_i(ptr_valid_i), .ptr_write_i(ptr_write_i),
   .ptr_addr_i(ptr_addr_i), .dma_i(dma_i), .mii_valid_i(mii_valid_i),
   .mii_write_i(mii_write_i), .rsp_o(rsp_o), .ptr_rvalid_o(ptr_rvalid_o),
   .dma_rvalid_o(dma_rvalid_o), .mii_rvalid_o(mii_rvalid_o),
   .serial_mode_o(serial_mode_o), .cs_pullup_en_o(cs_pullup_en_o),
   .cs_pulldown_en_o(cs_pulldown_en_o)
);
`default_nettype wire
